// *** hdl/tla_pkg.sv ***
// Shared constants and types for the temperature limit and ambient register block
package tla_pkg;

	localparam logic [7:0]  PTR_UPPER      = 8'h02;
	localparam logic [7:0]  PTR_LOWER      = 8'h03;
	localparam logic [7:0]  PTR_CRIT       = 8'h04;
	localparam logic [7:0]  PTR_AMBIENT    = 8'h05;

	localparam int          REG_W          = 16;
	localparam int          TEMP_W         = 13;
	localparam int          SIGN_BIT       = 12;
	localparam int          LIMIT_LSB      = 2;
	localparam int          FLAG_CRIT      = 15;
	localparam int          FLAG_UPPER     = 14;
	localparam int          FLAG_LOWER     = 13;
	localparam int          NUM_LIMITS     = 3;
	localparam int          IDX_UPPER      = 0;
	localparam int          IDX_LOWER      = 1;
	localparam int          IDX_CRIT       = 2;

	localparam logic [15:0] LIMIT_MASK     = 16'h1ffc;
	localparam logic [15:0] LIMIT_RESET    = 16'h0000;
	localparam logic [12:0] AMBIENT_RESET  = 13'h0000;
	localparam logic [15:0] UNMAPPED_VALUE = 16'h0000;

	typedef enum logic [1:0] {
		RES_HALF      = 2'b00,
		RES_QUARTER   = 2'b01,
		RES_EIGHTH    = 2'b10,
		RES_SIXTEENTH = 2'b11
	} tla_res_type;

	localparam tla_res_type RES_RESET      = RES_QUARTER;

endpackage

// *** hdl/tla_limit_reg.sv ***
// One programmable temperature limit register with write lock and field masking
`timescale 1ns/1ps
`default_nettype none
module tla_limit_reg
	import tla_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        wr_i,
	input  wire logic        locked_i,
	input  wire logic [15:0] data_i,
	output var  logic [15:0] value_o
);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			value_o <= LIMIT_RESET; // R14
		end else if (wr_i && !locked_i) begin // R12
			value_o <= data_i & LIMIT_MASK; // R1 R2 R13
		end
	end

endmodule
`default_nettype wire

// *** hdl/tla_compare.sv ***
// Signed comparison of the ambient value against one limit
`timescale 1ns/1ps
`default_nettype none
module tla_compare
	import tla_pkg::*;
(
	input  wire logic [12:0] ambient_i,
	input  wire logic [15:0] limit_i,
	output var  logic        above_o,
	output var  logic        below_o
);

	logic signed [12:0] amb_s;
	logic signed [12:0] lim_s;

	// Limit bits 12:2 line up with ambient bits 12:2, so both share one scale
	assign amb_s = $signed(ambient_i);
	assign lim_s = $signed(limit_i[SIGN_BIT:0]); // R3

	assign above_o = amb_s > lim_s; // R3
	assign below_o = amb_s < lim_s; // R3

endmodule
`default_nettype wire

// *** hdl/tla_regs.sv ***
// Limit and ambient temperature registers with comparison flags and alert
//
// Behaviour
// R1: Three 16-bit read/write limit registers
// R2: Sign bit 12, boundary 11:2, rest zero
// R3: Limits compared as two's complement values
// R4: Upper, lower, critical at pointers 2,3,4
// R5: Alert asserts when enabled and out of bounds
// R6: Read-only ambient word, 13-bit signed temperature
// R7: Ambient loaded whole once per conversion
// R8: Bit 15 set when ambient at/above critical
// R9: Bit 14 set when ambient above upper
// R10: Bit 13 set when ambient below lower
// R11: Low fraction bits zero per resolution
// R12: Window lock blocks upper/lower writes until reset
// R13: Unimplemented limit bits discard written data
// R14: Limit and ambient values clear to zero at reset; the ambient word then reads 0x8000 (critical flag set)
`timescale 1ns/1ps
`default_nettype none
module tla_regs
	import tla_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  reg_ptr_i,
	input  wire logic        wr_en_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic        rd_en_i,
	output var  logic [15:0] rd_data_o,
	output var  logic        rd_valid_o,
	input  wire logic        conv_valid_i,
	input  wire logic [12:0] conv_data_i,
	input  wire logic [1:0]  resolution_i,
	input  wire logic        alert_enable_i,
	input  wire logic        window_lock_i,
	output var  logic        window_locked_o,
	output var  logic        alert_o
);

	logic [15:0] limit_val [NUM_LIMITS];
	logic [NUM_LIMITS-1:0] above;
	logic [NUM_LIMITS-1:0] below;
	logic [12:0] ambient_temperature;
	logic        lock_q;
	logic        locked;
	logic        flag_crit;
	logic        flag_upper;
	logic        flag_lower;
	logic [15:0] ambient_word;
	logic [15:0] next_rd_data;

	// Pointer of limit register by index
	function automatic logic [7:0] limit_ptr(input int idx);
		case (idx)
			IDX_UPPER: limit_ptr = PTR_UPPER;
			IDX_LOWER: limit_ptr = PTR_LOWER;
			default:   limit_ptr = PTR_CRIT;
		endcase
	endfunction

	// Mask clearing fraction bits below the selected resolution
	function automatic logic [12:0] res_mask(input logic [1:0] res);
		case (res)
			RES_HALF:      res_mask = 13'h1ff8;
			RES_QUARTER:   res_mask = 13'h1ffc;
			RES_EIGHTH:    res_mask = 13'h1ffe;
			default:       res_mask = 13'h1fff;
		endcase
	endfunction

	// Sticky lock, released only by reset
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_q <= 1'b0;
		end else if (window_lock_i) begin
			lock_q <= 1'b1; // R12
		end
	end

	assign locked          = lock_q | window_lock_i;
	assign window_locked_o = lock_q;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_LIMITS; gi++) begin : g_limit
			tla_limit_reg u_limit (
				.ref_clk_i (ref_clk_i),
				.rst_n_i   (rst_n_i),
				.wr_i      (wr_en_i && (reg_ptr_i == limit_ptr(gi))), // R4
				.locked_i  ((gi == IDX_CRIT) ? 1'b0 : locked), // R12
				.data_i    (wr_data_i),
				.value_o   (limit_val[gi])
			);
			tla_compare u_cmp (
				.ambient_i (ambient_temperature),
				.limit_i   (limit_val[gi]),
				.above_o   (above[gi]),
				.below_o   (below[gi])
			);

			property p_limit_unimpl;
				@(posedge ref_clk_i) disable iff (!rst_n_i)
				(limit_val[gi] & ~LIMIT_MASK) == 16'h0000;
			endproperty
			a_limit_unimpl: assert property (p_limit_unimpl) // R2
			else $error("Unimplemented limit bits not zero");
		end
	endgenerate

	// Converter result replaces the buffered value in one step
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ambient_temperature <= AMBIENT_RESET; // R14
		end else if (conv_valid_i) begin
			ambient_temperature <= conv_data_i & res_mask(resolution_i); // R7 R11
		end
	end

	assign flag_crit  = ~below[IDX_CRIT]; // R8
	assign flag_upper = above[IDX_UPPER]; // R9
	assign flag_lower = below[IDX_LOWER]; // R10

	assign ambient_word = {flag_crit, flag_upper, flag_lower, ambient_temperature}; // R6

	always_comb begin
		case (reg_ptr_i)
			PTR_UPPER:   next_rd_data = limit_val[IDX_UPPER]; // R4
			PTR_LOWER:   next_rd_data = limit_val[IDX_LOWER]; // R4
			PTR_CRIT:    next_rd_data = limit_val[IDX_CRIT]; // R4
			PTR_AMBIENT: next_rd_data = ambient_word; // R6
			default:     next_rd_data = UNMAPPED_VALUE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o  <= 16'h0000;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= rd_en_i;
			if (rd_en_i) begin
				rd_data_o <= next_rd_data;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alert_o <= 1'b0;
		end else begin
			alert_o <= alert_enable_i && (flag_crit || flag_upper || flag_lower); // R5
		end
	end

	property p_limit_write;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_en_i && reg_ptr_i == PTR_CRIT) |=>
			limit_val[IDX_CRIT] == ($past(wr_data_i) & LIMIT_MASK);
	endproperty
	a_limit_write: assert property (p_limit_write) // R1
	else $error("Critical limit write not stored masked");

	property p_mask_discard;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_en_i && reg_ptr_i == PTR_UPPER && !locked) |=>
			limit_val[IDX_UPPER][15:13] == 3'b000 && limit_val[IDX_UPPER][1:0] == 2'b00 &&
			limit_val[IDX_UPPER][12:2] == $past(wr_data_i[12:2]);
	endproperty
	a_mask_discard: assert property (p_mask_discard) // R13
	else $error("Upper limit write mishandled field bits");

	property p_lock_blocks;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(lock_q && wr_en_i && (reg_ptr_i == PTR_UPPER || reg_ptr_i == PTR_LOWER)) |=>
			$stable(limit_val[IDX_UPPER]) && $stable(limit_val[IDX_LOWER]);
	endproperty
	a_lock_blocks: assert property (p_lock_blocks) // R12
	else $error("Locked window limit was written");

	property p_lock_sticky;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		lock_q |=> lock_q [*4];
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) // R12
	else $error("Window lock released without reset");

	property p_read_decode;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(rd_en_i && reg_ptr_i == PTR_LOWER) |=>
			rd_valid_o && rd_data_o == $past(limit_val[IDX_LOWER]);
	endproperty
	a_read_decode: assert property (p_read_decode) // R4
	else $error("Lower limit read returned wrong word");

	property p_amb_load;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		conv_valid_i |=>
			ambient_temperature == ($past(conv_data_i) & res_mask($past(resolution_i)));
	endproperty
	a_amb_load: assert property (p_amb_load) // R7
	else $error("Ambient value not loaded from conversion");

	property p_amb_hold;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!conv_valid_i |=> $stable(ambient_temperature);
	endproperty
	a_amb_hold: assert property (p_amb_hold) // R7
	else $error("Ambient value changed without conversion");

	property p_res_quarter;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(conv_valid_i && resolution_i == RES_QUARTER) |=> ambient_temperature[1:0] == 2'b00;
	endproperty
	a_res_quarter: assert property (p_res_quarter) // R11
	else $error("Quarter resolution left low bits set");

	property p_amb_read;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(rd_en_i && reg_ptr_i == PTR_AMBIENT) |=>
			rd_data_o[12:0] == $past(ambient_temperature);
	endproperty
	a_amb_read: assert property (p_amb_read) // R6
	else $error("Ambient read lost temperature field");

	property p_flag_crit;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(rd_en_i && reg_ptr_i == PTR_AMBIENT) |=> rd_data_o[FLAG_CRIT] ==
			($signed($past(ambient_temperature)) >= $signed($past(limit_val[IDX_CRIT][12:0])));
	endproperty
	a_flag_crit: assert property (p_flag_crit) // R8
	else $error("Critical flag wrong");

	property p_flag_upper;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(rd_en_i && reg_ptr_i == PTR_AMBIENT) |=> rd_data_o[FLAG_UPPER] ==
			($signed($past(ambient_temperature)) > $signed($past(limit_val[IDX_UPPER][12:0])));
	endproperty
	a_flag_upper: assert property (p_flag_upper) // R9 R3
	else $error("Upper flag wrong");

	property p_flag_lower;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(rd_en_i && reg_ptr_i == PTR_AMBIENT) |=> rd_data_o[FLAG_LOWER] ==
			($signed($past(ambient_temperature)) < $signed($past(limit_val[IDX_LOWER][12:0])));
	endproperty
	a_flag_lower: assert property (p_flag_lower) // R10 R3
	else $error("Lower flag wrong");

	property p_alert;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		1'b1 |=> alert_o == ($past(alert_enable_i) &&
			($past(flag_crit) || $past(flag_upper) || $past(flag_lower)));
	endproperty
	a_alert: assert property (p_alert) // R5
	else $error("Alert output does not follow flags");

	property p_lower_write;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_en_i && reg_ptr_i == PTR_LOWER && !locked) |=>
			limit_val[IDX_LOWER] == ($past(wr_data_i) & LIMIT_MASK);
	endproperty
	a_lower_write: assert property (p_lower_write) // R1
	else $error("Lower limit write not stored masked");

	// The critical limit stays writable under the window lock
	property p_crit_unlocked;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(lock_q && wr_en_i && reg_ptr_i == PTR_CRIT) |=>
			limit_val[IDX_CRIT] == ($past(wr_data_i) & LIMIT_MASK);
	endproperty
	a_crit_unlocked: assert property (p_crit_unlocked) // R12
	else $error("Critical limit write refused under window lock");

	property p_lock_latch;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		window_lock_i |=> lock_q && window_locked_o;
	endproperty
	a_lock_latch: assert property (p_lock_latch) // R12
	else $error("Window lock request not latched");

	property p_unmapped_read;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(rd_en_i && (reg_ptr_i < PTR_UPPER || reg_ptr_i > PTR_AMBIENT)) |=>
			rd_data_o == UNMAPPED_VALUE;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) // R4
	else $error("Unmapped pointer read returned data");

	property p_rd_idle;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!rd_en_i |=> !rd_valid_o && $stable(rd_data_o);
	endproperty
	a_rd_idle: assert property (p_rd_idle) // R6
	else $error("Read port changed without a read");

	property p_ambient_ro;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_en_i && reg_ptr_i == PTR_AMBIENT && !conv_valid_i) |=>
			$stable(ambient_temperature);
	endproperty
	a_ambient_ro: assert property (p_ambient_ro) // R6
	else $error("Ambient value changed by a host write");

	property p_res_half;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(conv_valid_i && resolution_i == RES_HALF) |=> ambient_temperature[2:0] == 3'b000;
	endproperty
	a_res_half: assert property (p_res_half) // R11
	else $error("Half resolution left low bits set");

endmodule
`default_nettype wire

// *** tb/tla_host_model.sv ***
// Host-side register access model for the limit and ambient registers
`timescale 1ns/1ps
`default_nettype none
module tla_host_model (
	input  wire logic        ref_clk_i,
	input  wire logic [15:0] rd_data_i,
	input  wire logic        rd_valid_i,
	output var  logic [7:0]  reg_ptr_o,
	output var  logic        wr_en_o,
	output var  logic [15:0] wr_data_o,
	output var  logic        rd_en_o
);
	initial begin
		reg_ptr_o = 8'h00;
		wr_en_o = 1'b0;
		wr_data_o = 16'h0000;
		rd_en_o = 1'b0;
	end
	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		@(negedge ref_clk_i);
		reg_ptr_o = p;
		wr_data_o = d;
		wr_en_o = 1'b1;
		@(negedge ref_clk_i);
		wr_en_o = 1'b0;
		// Released data must not look like the last word
		wr_data_o = ~d;
	endtask
	task automatic rd(input logic [7:0] p, output logic [15:0] d, output logic v);
		@(negedge ref_clk_i);
		reg_ptr_o = p;
		rd_en_o = 1'b1;
		@(negedge ref_clk_i);
		rd_en_o = 1'b0;
		v = rd_valid_i;
		d = rd_data_i;
	endtask
endmodule
`default_nettype wire

// *** tb/tla_regs_tb_top.sv ***
// Self-checking testbench for the limit and ambient register block
`timescale 1ns/1ps
`default_nettype none
module tla_regs_tb_top;
	import tla_pkg::*;
	logic        clk, rst_n, wr_en, rd_en, rd_valid, conv_valid;
	logic        alert_en, lock, locked, alert;
	logic [7:0]  ptr;
	logic [15:0] wr_data, rd_data;
	logic [12:0] conv_data;
	logic [1:0]  res;
	int          fails = 0;
	int          total_checks = 0;
	logic [12:0] vals [8] = '{13'h0000, 13'h0190, 13'h0191, 13'h1fc0,
		13'h1fbf, 13'h0320, 13'h031f, 13'h1000};

	tla_regs uut (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_ptr_i(ptr), .wr_en_i(wr_en),
		.wr_data_i(wr_data), .rd_en_i(rd_en), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.conv_valid_i(conv_valid), .conv_data_i(conv_data), .resolution_i(res),
		.alert_enable_i(alert_en), .window_lock_i(lock), .window_locked_o(locked),
		.alert_o(alert));
	tla_host_model host (.ref_clk_i(clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
		.reg_ptr_o(ptr), .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic results;
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic rdchk(input logic [7:0] p, input logic [15:0] e);
		logic [15:0] d;
		logic        v;
		host.rd(p, d, v);
		chk({15'h0000, v}, 16'h0001);
		chk(d, e);
	endtask

	task automatic conv(input logic [12:0] d, input logic [1:0] r);
		@(negedge clk);
		conv_data = d;
		res = r;
		conv_valid = 1'b1;
		@(negedge clk);
		conv_valid = 1'b0;
	endtask

	// Ambient word against upper 0x0190, lower 0x1fc0, critical 0x0320
	function automatic logic [15:0] amb(input logic [12:0] a);
		amb = {$signed(a) >= $signed(13'h0320), $signed(a) > $signed(13'h0190),
			$signed(a) < $signed(13'h1fc0), a};
	endfunction

	task automatic t_reset;
		rdchk(PTR_UPPER, 16'h0000);
		rdchk(PTR_LOWER, 16'h0000);
		rdchk(PTR_CRIT, 16'h0000);
		rdchk(PTR_AMBIENT, 16'h8000);
		rdchk(8'h00, 16'h0000);
		$display("Test reset done");
	endtask

	task automatic t_limits;
		for (int i = 0; i < 3; i++) begin
			host.wr(PTR_UPPER + 8'(i), 16'hffff);
			rdchk(PTR_UPPER + 8'(i), 16'h1ffc);
		end
		host.wr(PTR_UPPER, 16'h0190);
		host.wr(PTR_LOWER, 16'h1fc0);
		host.wr(PTR_CRIT, 16'h0320);
		host.wr(PTR_AMBIENT, 16'hffff);
		rdchk(PTR_UPPER, 16'h0190);
		rdchk(PTR_LOWER, 16'h1fc0);
		rdchk(PTR_CRIT, 16'h0320);
		rdchk(PTR_AMBIENT, 16'h0000);
		$display("Test limits done");
	endtask

	task automatic t_flags;
		logic [15:0] e;
		alert_en = 1'b1;
		for (int i = 0; i < 8; i++) begin
			e = amb(vals[i]);
			conv(vals[i], 2'b11);
			rdchk(PTR_AMBIENT, e);
			chk({15'h0000, alert}, {15'h0000, |e[15:13]});
		end
		alert_en = 1'b0;
		repeat (2) @(negedge clk);
		chk({15'h0000, alert}, 16'h0000);
		$display("Test flags done");
	endtask

	task automatic t_res;
		logic [12:0] t;
		for (int r = 0; r < 4; r++) begin
			t = 13'h0197 & (13'h1fff << (3 - r));
			conv(13'h0197, 2'(r));
			rdchk(PTR_AMBIENT, amb(t));
		end
		$display("Test resolution done");
	endtask

	task automatic t_lock;
		@(negedge clk);
		lock = 1'b1;
		@(negedge clk);
		lock = 1'b0;
		@(negedge clk);
		chk({15'h0000, locked}, 16'h0001);
		host.wr(PTR_UPPER, 16'h0050);
		host.wr(PTR_LOWER, 16'h0010);
		host.wr(PTR_CRIT, 16'h0100);
		rdchk(PTR_UPPER, 16'h0190);
		rdchk(PTR_LOWER, 16'h1fc0);
		rdchk(PTR_CRIT, 16'h0100);
		$display("Test lock done");
	endtask

	// Reset in mid-run clears limits, ambient value and the window lock
	task automatic t_rst2;
		host.wr(PTR_CRIT, 16'h0040);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk({15'h0000, locked}, 16'h0000);
		rdchk(PTR_UPPER, 16'h0000);
		rdchk(PTR_CRIT, 16'h0000);
		rdchk(PTR_AMBIENT, 16'h8000);
		host.wr(PTR_UPPER, 16'h0050);
		rdchk(PTR_UPPER, 16'h0050);
		$display("Test second reset done");
	endtask

	initial begin
		#500000;
		fails++;
		results;
	end

	initial begin
		rst_n = 1'b0;
		conv_valid = 1'b0;
		conv_data = 13'h0000;
		res = RES_QUARTER;
		alert_en = 1'b0;
		lock = 1'b0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		t_reset;
		t_limits;
		t_flags;
		t_res;
		t_lock;
		t_rst2;
		results;
	end
endmodule
`default_nettype wire
